// [rtl/hlcr_params.svh]
// Constants for the host link control register slice.
// Behaviour
// - Failure capture records bus and node number.
// - Failure capture records upper destination offset.
// - Vendor register read-only fixed constant.
// - One control register, set and clear addresses.
// - Bit 30 bypasses DMA byte swapping.
// - Bit 23 loaded from EEPROM, clear-only.
// - Software leaves enhancements alone while 23 low.
// - Software sets 22 only with 23, 17.
// - Bit 19 gates link to PHY traffic.
// - Stopped PHY clock access gives target abort.
// - Abort suppress returns all ones instead.
// - DCh-F0h and 100h-11Ch are PHY clocked.
// - Software waits 10 ms after link power.
// - Bit 18 enables posted writes.
// - Software changes bit 18 only link inactive.
// - Reserved control bits read as zero.
// - Bit 17 cleared by reset, disconnects link.
// - Bit 16 soft reset, reads one meanwhile.
`ifndef HLCR_PARAMS_SVH
`define HLCR_PARAMS_SVH

`define HLCR_AW            12
`define HLCR_OFS_FAIL_HIGH 12'h03C
`define HLCR_OFS_VENDOR    12'h040
`define HLCR_OFS_CTRL_SET  12'h050
`define HLCR_OFS_CTRL_CLR  12'h054
`define HLCR_PHY_LO1       12'h0DC
`define HLCR_PHY_HI1       12'h0F0
`define HLCR_PHY_LO2       12'h100
`define HLCR_PHY_HI2       12'h11C

// Arbitrary neutral value, not a real maker code.
`define HLCR_VENDOR_VAL    32'h0012_3450
`define HLCR_ALL_ONES      32'hFFFF_FFFF
`define HLCR_ZERO          32'h0000_0000

`define HLCR_BIT_SWAP      30
`define HLCR_BIT_ENH_ALLOW 23
`define HLCR_BIT_ENH_ACT   22
`define HLCR_BIT_PWR       19
`define HLCR_BIT_BWA       18
`define HLCR_BIT_LINK      17
`define HLCR_BIT_SRST      16
`define HLCR_REQ_MSB       31
`define HLCR_REQ_LSB       16
`define HLCR_OFS_MSB       15
`define HLCR_OFS_LSB       0

`define HLCR_SRST_CYCLES   5'h10
`define HLCR_SETTLE_MS     10
`define HLCR_CLK_KHZ       40000
`define HLCR_SETTLE_CYCLES (`HLCR_SETTLE_MS * `HLCR_CLK_KHZ)

`endif

// [rtl/hlcr_pkg.sv]
// Types shared by both ends of the host link control slice.
package hlcr_pkg;
   typedef logic [31:0] hlcr_word_type;
   typedef logic [11:0] hlcr_addr_type;
   typedef enum logic [1:0]
   {
      HLCR_IDLE   = 2'b00,
      HLCR_SETUP  = 2'b01,
      HLCR_ACCESS = 2'b11
   } hlcr_state_type;
endpackage

// [rtl/hlcr_apb_if.sv]
// APB carrier between the host end and the device end.
`timescale 1ns/1ps
interface hlcr_apb_if;
   import hlcr_pkg::*;
   hlcr_addr_type paddr;
   logic          psel;
   logic          penable;
   logic          pwrite;
   hlcr_word_type pwdata;
   hlcr_word_type prdata;
   logic          pready;
   logic          pslverr;

   modport device
   (
      input  paddr, psel, penable, pwrite, pwdata,
      output prdata, pready, pslverr
   );
   modport host
   (
      output paddr, psel, penable, pwrite, pwdata,
      input  prdata, pready, pslverr
   );
endinterface

// [rtl/hlcr_device.sv]
// Device end: register slice with failure capture and control flags.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "hlcr_params.svh"
module hlcr_device
   import hlcr_pkg::*;
(
   input  wire logic        REF_CLK_IN,
   input  wire logic        RESET_IN,
   hlcr_apb_if.device       APB,
   input  wire logic        PHY_CLOCK_RUNNING_IN,
   input  wire logic        ABORT_SUPPRESS_IN,
   input  wire logic        EEPROM_LOAD_IN,
   input  wire logic        EEPROM_ENH_ALLOWED_IN,
   input  wire logic        WRITE_FAIL_IN,
   input  wire logic [15:0] FAIL_REQUESTER_IN,
   input  wire logic [15:0] FAIL_OFFSET_UPPER_IN,
   input  wire logic [31:0] DMA_DATA_IN,
   input  wire logic        PKT_RX_VALID_IN,
   output logic [31:0]      DMA_DATA_OUT,
   output logic             PKT_RX_ACCEPT_OUT,
   output logic             SWAP_BYPASS_OUT,
   output logic             ENH_CONFIG_ALLOWED_OUT,
   output logic             ENH_ACTIVE_OUT,
   output logic             LINK_POWER_ON_OUT,
   output logic             BUFFERED_WRITE_ALLOW_OUT,
   output logic             LINK_ACTIVE_OUT,
   output logic             SOFTWARE_REINIT_OUT
);

   ////////////////////////////////////////////////////////////////////
   // Bus phase decode.

   logic          setup;
   logic          access;
   logic          wr_set;
   logic          wr_clr;
   logic          in_phy;
   logic          pready_ff;
   logic          pslverr_ff;
   hlcr_word_type prdata_ff;
   hlcr_word_type nxt_prdata;
   logic          nxt_pslverr;

   // Setup cycle is the decode cycle; the access cycle then completes.
   assign setup  = APB.psel & ~APB.penable;
   assign access = APB.psel & APB.penable & pready_ff;
   assign wr_set = access & APB.pwrite
                   & (APB.paddr == `HLCR_OFS_CTRL_SET);
   assign wr_clr = access & APB.pwrite
                   & (APB.paddr == `HLCR_OFS_CTRL_CLR);

   // Address windows that live on the PHY side clock.
   assign in_phy = ((APB.paddr >= `HLCR_PHY_LO1)
                    && (APB.paddr <= `HLCR_PHY_HI1))
                   || ((APB.paddr >= `HLCR_PHY_LO2)
                    && (APB.paddr <= `HLCR_PHY_HI2));

   ////////////////////////////////////////////////////////////////////
   // Control flags.

   logic       swap_ff;
   logic       allow_ff;
   logic       act_ff;
   logic       pwr_ff;
   logic       bwa_ff;
   logic       link_ff;
   logic       srst_ff;
   logic [4:0] srst_cnt_ff;
   logic       srst_start;
   logic       srst_done;
   logic       ctl_wr_ok;

   // Soft reset begins on a set-address write of bit 16.
   assign srst_start = wr_set & APB.pwdata[`HLCR_BIT_SRST]
                       & ~srst_ff;
   assign srst_done  = srst_ff
                       & (srst_cnt_ff == (`HLCR_SRST_CYCLES - 5'h01));
   // Flag writes other than a bit 23 clear are dropped during a soft reset so the reset is clean.
   assign ctl_wr_ok  = ~srst_ff & ~srst_start;

   // Soft reset flag and its duration counter.
   always_ff @(posedge REF_CLK_IN)
   begin
      if (RESET_IN)
      begin
         srst_ff     <= 1'b0;
         srst_cnt_ff <= 5'h00;
      end
      else if (srst_start)
      begin
         srst_ff     <= 1'b1;
         srst_cnt_ff <= 5'h00;
      end
      else if (srst_done)
      begin
         srst_ff     <= 1'b0;
      end
      else if (srst_ff)
      begin
         srst_cnt_ff <= srst_cnt_ff + 5'h01;
      end
   end

   // Read/set/clear flags; a soft reset returns them to zero.
   always_ff @(posedge REF_CLK_IN)
   begin
      if (RESET_IN || srst_start)
      begin
         swap_ff <= 1'b0;
         act_ff  <= 1'b0;
         pwr_ff  <= 1'b0;
         bwa_ff  <= 1'b0;
         link_ff <= 1'b0;
      end
      else if (ctl_wr_ok && wr_set)
      begin
         swap_ff <= swap_ff | APB.pwdata[`HLCR_BIT_SWAP];
         act_ff  <= act_ff  | APB.pwdata[`HLCR_BIT_ENH_ACT];
         pwr_ff  <= pwr_ff  | APB.pwdata[`HLCR_BIT_PWR];
         bwa_ff  <= bwa_ff  | APB.pwdata[`HLCR_BIT_BWA];
         link_ff <= link_ff | APB.pwdata[`HLCR_BIT_LINK];
      end
      else if (ctl_wr_ok && wr_clr)
      begin
         swap_ff <= swap_ff & ~APB.pwdata[`HLCR_BIT_SWAP];
         act_ff  <= act_ff  & ~APB.pwdata[`HLCR_BIT_ENH_ACT];
         pwr_ff  <= pwr_ff  & ~APB.pwdata[`HLCR_BIT_PWR];
         bwa_ff  <= bwa_ff  & ~APB.pwdata[`HLCR_BIT_BWA];
         link_ff <= link_ff & ~APB.pwdata[`HLCR_BIT_LINK];
      end
   end

   // Enhancement permission: EEPROM load wins over a software clear.
   always_ff @(posedge REF_CLK_IN)
   begin
      if (RESET_IN)
      begin
         allow_ff <= 1'b0;
      end
      else if (EEPROM_LOAD_IN)
      begin
         allow_ff <= EEPROM_ENH_ALLOWED_IN;
      end
      else if (wr_clr && APB.pwdata[`HLCR_BIT_ENH_ALLOW])
      begin
         allow_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Posted write failure capture.

   logic [15:0] fail_req_ff;
   logic [15:0] fail_ofs_ff;

   // Only a new failure overwrites; reads and soft reset leave it.
   always_ff @(posedge REF_CLK_IN)
   begin
      if (RESET_IN)
      begin
         fail_req_ff <= 16'h0000;
         fail_ofs_ff <= 16'h0000;
      end
      else if (WRITE_FAIL_IN)
      begin
         fail_req_ff <= FAIL_REQUESTER_IN;
         fail_ofs_ff <= FAIL_OFFSET_UPPER_IN;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read decode and abort handling.

   function automatic hlcr_word_type ctrl_word();
      hlcr_word_type w;
      w                     = `HLCR_ZERO;
      w[`HLCR_BIT_SWAP]      = swap_ff;
      w[`HLCR_BIT_ENH_ALLOW] = allow_ff;
      w[`HLCR_BIT_ENH_ACT]   = act_ff;
      w[`HLCR_BIT_PWR]       = pwr_ff;
      w[`HLCR_BIT_BWA]       = bwa_ff;
      w[`HLCR_BIT_LINK]      = link_ff;
      w[`HLCR_BIT_SRST]      = srst_ff;
      return w;
   endfunction

   // Read data is chosen in the setup cycle and held for the access.
   always_comb
   begin
      nxt_prdata  = `HLCR_ZERO;
      nxt_pslverr = 1'b0;
      if (in_phy && !PHY_CLOCK_RUNNING_IN)
      begin
         if (ABORT_SUPPRESS_IN)
         begin
            nxt_prdata = `HLCR_ALL_ONES;
         end
         else
         begin
            nxt_pslverr = 1'b1;
         end
      end
      else
      begin
         case (APB.paddr)
            `HLCR_OFS_FAIL_HIGH:
               nxt_prdata = {fail_req_ff, fail_ofs_ff};
            `HLCR_OFS_VENDOR:
               nxt_prdata = `HLCR_VENDOR_VAL;
            `HLCR_OFS_CTRL_SET,
            `HLCR_OFS_CTRL_CLR:
               nxt_prdata = ctrl_word();
            default:
               nxt_prdata = `HLCR_ZERO;
         endcase
      end
   end

   // One wait-free access: ready in the cycle after setup.
   always_ff @(posedge REF_CLK_IN)
   begin
      if (RESET_IN)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= `HLCR_ZERO;
      end
      else
      begin
         pready_ff  <= setup;
         pslverr_ff <= setup & nxt_pslverr;
         if (setup)
         begin
            prdata_ff <= nxt_prdata;
         end
      end
   end

   assign APB.pready  = pready_ff;
   assign APB.pslverr = pslverr_ff;
   assign APB.prdata  = prdata_ff;

   ////////////////////////////////////////////////////////////////////
   // Effects of the flags on the data path.

   logic [31:0] dma_ff;
   logic        rx_acc_ff;

   // Swap bytes unless bypass is set; one register stage of latency.
   always_ff @(posedge REF_CLK_IN)
   begin
      if (RESET_IN)
      begin
         dma_ff    <= `HLCR_ZERO;
         rx_acc_ff <= 1'b0;
      end
      else
      begin
         dma_ff    <= swap_ff ? DMA_DATA_IN
                      : {DMA_DATA_IN[7:0], DMA_DATA_IN[15:8],
                         DMA_DATA_IN[23:16], DMA_DATA_IN[31:24]};
         // No packet is taken while the link is off or unpowered.
         rx_acc_ff <= PKT_RX_VALID_IN & link_ff & pwr_ff;
      end
   end

   assign DMA_DATA_OUT             = dma_ff;
   assign PKT_RX_ACCEPT_OUT        = rx_acc_ff;
   assign SWAP_BYPASS_OUT          = swap_ff;
   assign ENH_CONFIG_ALLOWED_OUT   = allow_ff;
   assign ENH_ACTIVE_OUT           = act_ff;
   assign LINK_POWER_ON_OUT        = pwr_ff;
   assign BUFFERED_WRITE_ALLOW_OUT = bwa_ff;
   assign LINK_ACTIVE_OUT          = link_ff;
   assign SOFTWARE_REINIT_OUT      = srst_ff;

endmodule

// [rtl/hlcr_host.sv]
// Host end: APB master that issues register commands for software.
`timescale 1ns/1ps
`include "hlcr_params.svh"
module hlcr_host
   import hlcr_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES = `HLCR_SETTLE_CYCLES
)
(
   input  wire logic        REF_CLK_IN,
   input  wire logic        RESET_IN,
   hlcr_apb_if.host         APB,
   input  wire logic        CMD_VALID_IN,
   input  wire logic        CMD_WRITE_IN,
   input  wire logic [11:0] CMD_ADDR_IN,
   input  wire logic [31:0] CMD_WDATA_IN,
   output logic             CMD_READY_OUT,
   output logic             RSP_VALID_OUT,
   output logic [31:0]      RSP_RDATA_OUT,
   output logic             RSP_ERROR_OUT,
   output logic             RSP_REFUSED_OUT
);

   ////////////////////////////////////////////////////////////////////
   // State and shadow of the control register.

   hlcr_state_type state_ff;
   hlcr_state_type nxt_state;
   hlcr_word_type  shadow_ff;
   logic [19:0]    settle_ff;
   logic [19:0]    nxt_settle;
   logic           ready_ff;
   logic           take;
   logic           refuse;
   logic           done;
   logic           is_set;
   logic           is_clr;
   hlcr_addr_type  paddr_ff;
   logic           pwrite_ff;
   hlcr_word_type  pwdata_ff;
   logic           psel_ff;
   logic           penable_ff;
   logic           rsp_valid_ff;
   hlcr_word_type  rsp_rdata_ff;
   logic           rsp_err_ff;
   logic           rsp_ref_ff;

   assign take   = CMD_VALID_IN & ready_ff;
   assign is_set = CMD_ADDR_IN == `HLCR_OFS_CTRL_SET;
   assign is_clr = CMD_ADDR_IN == `HLCR_OFS_CTRL_CLR;
   assign done   = (state_ff == HLCR_ACCESS) & APB.pready;

   // Writes that would break the software side of the flag protocol.
   always_comb
   begin
      refuse = 1'b0;
      if (CMD_WRITE_IN && (is_set || is_clr))
      begin
         if (CMD_WDATA_IN[`HLCR_BIT_ENH_ACT]
             && !shadow_ff[`HLCR_BIT_ENH_ALLOW])
         begin
            refuse = 1'b1;
         end
         if (is_set && CMD_WDATA_IN[`HLCR_BIT_ENH_ACT]
             && !shadow_ff[`HLCR_BIT_LINK])
         begin
            refuse = 1'b1;
         end
         if (CMD_WDATA_IN[`HLCR_BIT_BWA] && shadow_ff[`HLCR_BIT_LINK])
         begin
            refuse = 1'b1;
         end
      end
   end

   // Next state and settle count after powering the link.
   always_comb
   begin
      nxt_state  = state_ff;
      nxt_settle = settle_ff;
      if (settle_ff != 20'h00000)
      begin
         nxt_settle = settle_ff - 20'h00001;
      end
      case (state_ff)
         HLCR_IDLE:
            if (take && !refuse)
            begin
               nxt_state = HLCR_SETUP;
            end
         HLCR_SETUP:
            nxt_state = HLCR_ACCESS;
         HLCR_ACCESS:
            if (APB.pready)
            begin
               nxt_state = HLCR_IDLE;
               if (pwrite_ff && !APB.pslverr
                   && (paddr_ff == `HLCR_OFS_CTRL_SET)
                   && pwdata_ff[`HLCR_BIT_PWR])
               begin
                  nxt_settle = SETTLE_CYCLES[19:0];
               end
            end
         default:
            nxt_state = HLCR_IDLE;
      endcase
   end

   // Bus phase registers; request held until pready is sampled.
   always_ff @(posedge REF_CLK_IN)
   begin
      if (RESET_IN)
      begin
         state_ff   <= HLCR_IDLE;
         settle_ff  <= 20'h00000;
         ready_ff   <= 1'b0;
         psel_ff    <= 1'b0;
         penable_ff <= 1'b0;
         paddr_ff   <= 12'h000;
         pwrite_ff  <= 1'b0;
         pwdata_ff  <= `HLCR_ZERO;
      end
      else
      begin
         state_ff   <= nxt_state;
         settle_ff  <= nxt_settle;
         // Commands wait while the PHY side clock settles.
         ready_ff   <= (nxt_state == HLCR_IDLE)
                       && (nxt_settle == 20'h00000);
         psel_ff    <= nxt_state != HLCR_IDLE;
         penable_ff <= nxt_state == HLCR_ACCESS;
         if (take && !refuse)
         begin
            paddr_ff  <= CMD_ADDR_IN;
            pwrite_ff <= CMD_WRITE_IN;
            pwdata_ff <= CMD_WDATA_IN;
         end
      end
   end

   // Response and shadow update at the completing edge.
   always_ff @(posedge REF_CLK_IN)
   begin
      if (RESET_IN)
      begin
         rsp_valid_ff <= 1'b0;
         rsp_rdata_ff <= `HLCR_ZERO;
         rsp_err_ff   <= 1'b0;
         rsp_ref_ff   <= 1'b0;
         shadow_ff    <= `HLCR_ZERO;
      end
      else
      begin
         rsp_valid_ff <= done | (take & refuse);
         rsp_ref_ff   <= take & refuse;
         rsp_err_ff   <= done & APB.pslverr;
         if (done)
         begin
            rsp_rdata_ff <= pwrite_ff ? `HLCR_ZERO : APB.prdata;
         end
         if (done && !APB.pslverr && !pwrite_ff
             && ((paddr_ff == `HLCR_OFS_CTRL_SET)
              || (paddr_ff == `HLCR_OFS_CTRL_CLR)))
         begin
            shadow_ff <= APB.prdata;
         end
         else if (done && !APB.pslverr && pwrite_ff
                  && (paddr_ff == `HLCR_OFS_CTRL_SET))
         begin
            shadow_ff <= shadow_ff | (pwdata_ff
                         & ~(32'h1 << `HLCR_BIT_ENH_ALLOW));
         end
         else if (done && !APB.pslverr && pwrite_ff
                  && (paddr_ff == `HLCR_OFS_CTRL_CLR))
         begin
            shadow_ff <= shadow_ff & ~pwdata_ff;
         end
      end
   end

   assign APB.psel        = psel_ff;
   assign APB.penable     = penable_ff;
   assign APB.paddr       = paddr_ff;
   assign APB.pwrite      = pwrite_ff;
   assign APB.pwdata      = pwdata_ff;
   assign CMD_READY_OUT   = ready_ff;
   assign RSP_VALID_OUT   = rsp_valid_ff;
   assign RSP_RDATA_OUT   = rsp_rdata_ff;
   assign RSP_ERROR_OUT   = rsp_err_ff;
   assign RSP_REFUSED_OUT = rsp_ref_ff;

endmodule

// [verif/hlcr_apb_sva.sv]
// Concurrent checks on the APB link between the host and device ends.
`timescale 1ns/1ps
`include "hlcr_params.svh"
module hlcr_apb_sva
   import hlcr_pkg::*;
(
   input wire logic          REF_CLK_IN,
   input wire logic          RESET_IN,
   input wire hlcr_addr_type paddr,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire hlcr_word_type pwdata,
   input wire hlcr_word_type prdata,
   input wire logic          pready,
   input wire logic          pslverr
);
   // Flags 30, 19, 18 and 17 only; bit 23 is loaded from the EEPROM inside the device.
   localparam hlcr_word_type TRACK = 32'h400E_0000;
   localparam hlcr_word_type RSVD  = 32'hBF30_FFFF;
   logic          wr_done;
   logic          rd_done;
   logic          ctrl;
   logic          in_phy;
   logic          srst_wr;
   hlcr_word_type shadow_ff;
   logic [4:0]    age_ff;

   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (RESET_IN);
   //////////////////////////////////////////////////////////////////////
   // Completed transfers and address classes seen on the link.
   assign wr_done = psel && penable && pready && pwrite;
   assign rd_done = psel && penable && pready && !pwrite;
   assign ctrl    = paddr == `HLCR_OFS_CTRL_SET || paddr == `HLCR_OFS_CTRL_CLR;
   assign in_phy  = (paddr >= `HLCR_PHY_LO1 && paddr <= `HLCR_PHY_HI1) ||
                    (paddr >= `HLCR_PHY_LO2 && paddr <= `HLCR_PHY_HI2);
   assign srst_wr = wr_done && paddr == `HLCR_OFS_CTRL_SET &&
                    pwdata[`HLCR_BIT_SRST];

   // Expected flags, rebuilt only from writes that really reach the device.
   always_ff @(posedge REF_CLK_IN)
   begin
      if (RESET_IN || srst_wr)
         shadow_ff <= 32'h0000_0000;
      else if (wr_done && paddr == `HLCR_OFS_CTRL_SET)
         shadow_ff <= shadow_ff | (pwdata & TRACK);
      else if (wr_done && paddr == `HLCR_OFS_CTRL_CLR)
         shadow_ff <= shadow_ff & ~(pwdata & TRACK);
   end

   // Cycles since the last soft reset request; saturates to stay quiet.
   always_ff @(posedge REF_CLK_IN)
   begin
      if (RESET_IN)
         age_ff <= 5'h1F;
      else if (srst_wr)
         age_ff <= 5'h00;
      else if (age_ff != 5'h1F)
         age_ff <= age_ff + 5'h01;
   end

   sequence rd_setup_s;
      psel && !penable && !pwrite;
   endsequence
   sequence rd_ctrl_s;
      rd_done && ctrl;
   endsequence
   //////////////////////////////////////////////////////////////////////
   chk_vendor_fixed:
   assert property (rd_setup_s ##0 paddr == `HLCR_OFS_VENDOR |=>
                    prdata == `HLCR_VENDOR_VAL)
      else $error("vendor word not the fixed value");
   chk_rsvd_zero:
   assert property (rd_setup_s ##0 ctrl |=> (prdata & RSVD) == 32'h0000_0000)
      else $error("reserved control bit read as one");
   chk_ctrl_track:
   assert property (rd_ctrl_s |-> (prdata & TRACK) == shadow_ff)
      else $error("control flags differ from written history");
   chk_srst_busy:
   assert property (rd_ctrl_s ##0 age_ff <= 5'h0D |-> prdata[`HLCR_BIT_SRST])
      else $error("soft reset flag dropped too early");
   chk_srst_done:
   assert property (rd_ctrl_s ##0 age_ff >= 5'h14 |-> !prdata[`HLCR_BIT_SRST])
      else $error("soft reset flag stuck");
   chk_err_window:
   assert property (pready && pslverr |-> in_phy)
      else $error("error answer outside the phy window");
   chk_ready_next:
   assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_pulse:
   assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   chk_hold_access:
   assert property (psel && !penable |=> psel && penable && $stable(paddr) &&
                    $stable(pwrite) && $stable(pwdata))
      else $error("request changed between setup and access");
endmodule

// [verif/host_link_control_registers_bench.sv]
// Self-checking bench joining the host and device ends over APB.
`timescale 1ns/1ps
`include "hlcr_params.svh"
module host_link_control_registers_bench
   import hlcr_pkg::*;
;
   localparam int            SETTLE = 20;
   localparam hlcr_addr_type SET    = `HLCR_OFS_CTRL_SET;
   localparam hlcr_addr_type CLR    = `HLCR_OFS_CTRL_CLR;
   logic          clk, rst, phy_run, ab_sup, ee_ld, ee_ok, wfail, pkt_v;
   logic          cmd_v, cmd_w, cmd_rdy, rsp_v, rsp_e, rsp_r, er, rf;
   logic          pkt_acc, swp, eca, ena, lpo, bwa, lnk, srst;
   logic [15:0]   f_req, f_ofs;
   hlcr_addr_type cmd_a;
   hlcr_word_type cmd_d, dma_in, dma_out, rsp_d, rd;
   int            fails, n_checks;
   hlcr_addr_type pa [7] = '{12'h0DC, 12'h0F0, 12'h100, 12'h11C,
                             12'h0F4, 12'h0D8, 12'h060};
   logic          pe [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
   logic [15:0]   fq [2] = '{16'hA5C3, 16'h5A3C};
   logic [15:0]   fo [2] = '{16'h1234, 16'hFEDC};
   hlcr_apb_if    bus ();
   //////////////////////////////////////////////////////////////////////
   // Both ends face each other; the checker watches the link between.
   hlcr_device hlcr_device_i
   (
      .REF_CLK_IN(clk), .RESET_IN(rst), .APB(bus),
      .PHY_CLOCK_RUNNING_IN(phy_run), .ABORT_SUPPRESS_IN(ab_sup),
      .EEPROM_LOAD_IN(ee_ld), .EEPROM_ENH_ALLOWED_IN(ee_ok),
      .WRITE_FAIL_IN(wfail), .FAIL_REQUESTER_IN(f_req),
      .FAIL_OFFSET_UPPER_IN(f_ofs), .DMA_DATA_IN(dma_in),
      .PKT_RX_VALID_IN(pkt_v), .DMA_DATA_OUT(dma_out),
      .PKT_RX_ACCEPT_OUT(pkt_acc), .SWAP_BYPASS_OUT(swp),
      .ENH_CONFIG_ALLOWED_OUT(eca), .ENH_ACTIVE_OUT(ena),
      .LINK_POWER_ON_OUT(lpo), .BUFFERED_WRITE_ALLOW_OUT(bwa),
      .LINK_ACTIVE_OUT(lnk), .SOFTWARE_REINIT_OUT(srst)
   );
   hlcr_host #(.SETTLE_CYCLES(SETTLE)) hlcr_host_i
   (
      .REF_CLK_IN(clk), .RESET_IN(rst), .APB(bus),
      .CMD_VALID_IN(cmd_v), .CMD_WRITE_IN(cmd_w), .CMD_ADDR_IN(cmd_a),
      .CMD_WDATA_IN(cmd_d), .CMD_READY_OUT(cmd_rdy),
      .RSP_VALID_OUT(rsp_v), .RSP_RDATA_OUT(rsp_d),
      .RSP_ERROR_OUT(rsp_e), .RSP_REFUSED_OUT(rsp_r)
   );
   hlcr_apb_sva hlcr_apb_sva_i
   (
      .REF_CLK_IN(clk), .RESET_IN(rst), .paddr(bus.paddr),
      .psel(bus.psel), .penable(bus.penable), .pwrite(bus.pwrite),
      .pwdata(bus.pwdata), .prdata(bus.prdata), .pready(bus.pready),
      .pslverr(bus.pslverr)
   );
   //////////////////////////////////////////////////////////////////////
   // One command through the host port; waits on its handshake only.
   task automatic cmd(input logic w, input hlcr_addr_type a,
                      input hlcr_word_type d);
      @(posedge clk);
      cmd_v <= 1'b1;
      cmd_w <= w;
      cmd_a <= a;
      cmd_d <= d;
      @(negedge clk);
      while (cmd_rdy !== 1'b1)
         @(negedge clk);
      @(posedge clk);
      cmd_v <= 1'b0;
      @(negedge clk);
      while (rsp_v !== 1'b1)
         @(negedge clk);
      {rd, er, rf} = {rsp_d, rsp_e, rsp_r};
   endtask

   task automatic pulse(input logic ee, input logic [15:0] q,
                        input logic [15:0] o);
      @(posedge clk);
      ee_ld <= ee;
      ee_ok <= q[0];
      wfail <= !ee;
      f_req <= q;
      f_ofs <= o;
      @(posedge clk);
      ee_ld <= 1'b0;
      wfail <= 1'b0;
   endtask

   task automatic chk32(input string nm, input hlcr_word_type e,
                        input hlcr_word_type g);
      n_checks++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH %s exp %b got %b", nm, e, g);
      end
   endtask

   task automatic final_report();
      if (fails == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   // Free-running clock at 40 MHz.
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // The whole run needs a few hundred cycles; this cuts a hang short.
   initial
   begin
      repeat (5000) @(posedge clk);
      fails++;
      final_report();
   end

   // Main sequence of register scenarios.
   initial
   begin
      {rst, phy_run, ee_ok} = 3'b111;
      {ab_sup, ee_ld, wfail, pkt_v, cmd_v, cmd_w} = 6'h00;
      {f_req, f_ofs, cmd_a, cmd_d} = '0;
      dma_in = 32'h1122_3344;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      cmd(1'b1, `HLCR_OFS_VENDOR, 32'hFFFF_FFFF);
      cmd(1'b0, `HLCR_OFS_VENDOR, 32'h0000_0000);
      chk32("vendor", `HLCR_VENDOR_VAL, rd);
      cmd(1'b1, SET, 32'hBF30_FFFF);
      cmd(1'b0, CLR, 32'h0000_0000);
      chk32("ctrl_rsvd", 32'h0000_0000, rd);
      // Two captures, each read twice to show reads leave it alone.
      for (int j = 0; j < 2; j++)
      begin
         pulse(1'b0, fq[j], fo[j]);
         cmd(1'b0, `HLCR_OFS_FAIL_HIGH, 32'h0000_0000);
         chk32("fail_cap", {fq[j], fo[j]}, rd);
         cmd(1'b0, `HLCR_OFS_FAIL_HIGH, 32'h0000_0000);
         chk32("fail_hold", {fq[j], fo[j]}, rd);
      end
      pulse(1'b1, 16'h0001, 16'h0000);
      cmd(1'b0, SET, 32'h0000_0000);
      chk32("allow_load", 32'h0080_0000, rd);
      chk1("allow_out", 1'b1, eca);
      cmd(1'b1, CLR, 32'h0080_0000);
      cmd(1'b1, SET, 32'h0080_0000);
      cmd(1'b0, CLR, 32'h0000_0000);
      chk32("allow_clear", 32'h0000_0000, rd);
      cmd(1'b1, SET, 32'h0040_0000);
      chk1("enh_blocked", 1'b1, rf);
      pulse(1'b1, 16'h0001, 16'h0000);
      cmd(1'b0, SET, 32'h0000_0000);
      cmd(1'b1, SET, 32'h0040_0000);
      chk1("enh_nolink", 1'b1, rf);
      cmd(1'b1, SET, 32'h0002_0000);
      cmd(1'b1, SET, 32'h0040_0000);
      chk1("enh_taken", 1'b0, rf);
      cmd(1'b0, CLR, 32'h0000_0000);
      chk32("enh_word", 32'h00C2_0000, rd);
      chk1("enh_out", 1'b1, ena);
      cmd(1'b1, SET, 32'h0004_0000);
      chk1("bwa_linked", 1'b1, rf);
      cmd(1'b1, CLR, 32'h0002_0000);
      chk1("link_out", 1'b0, lnk);
      cmd(1'b1, SET, 32'h0004_0000);
      chk1("bwa_taken", 1'b0, rf);
      chk1("bwa_out", 1'b1, bwa);
      cmd(1'b1, SET, 32'h4000_0000);
      @(negedge clk);
      chk32("dma_straight", 32'h1122_3344, dma_out);
      chk1("swap_out", 1'b1, swp);
      cmd(1'b1, CLR, 32'h4000_0000);
      @(negedge clk);
      chk32("dma_swapped", 32'h4433_2211, dma_out);
      @(posedge clk);
      pkt_v <= 1'b1;
      cmd(1'b1, SET, 32'h000A_0000);
      repeat (10) @(negedge clk);
      chk1("settle_hold", 1'b0, cmd_rdy);
      chk1("rx_on", 1'b1, pkt_acc);
      cmd(1'b1, CLR, 32'h0008_0000);
      @(negedge clk);
      chk1("rx_off", 1'b0, pkt_acc);
      chk1("lps_out", 1'b0, lpo);
      // Phy window with its clock stopped, then with suppression.
      @(posedge clk);
      phy_run <= 1'b0;
      foreach (pa[i])
      begin
         cmd(1'b0, pa[i], 32'h0000_0000);
         chk1("phy_abort", pe[i], er);
      end
      @(posedge clk);
      ab_sup <= 1'b1;
      cmd(1'b0, 12'h0E0, 32'h0000_0000);
      chk1("sup_err", 1'b0, er);
      chk32("sup_data", 32'hFFFF_FFFF, rd);
      @(posedge clk);
      phy_run <= 1'b1;
      cmd(1'b1, 12'h060, 32'hFFFF_FFFF);
      cmd(1'b0, 12'h060, 32'h0000_0000);
      chk32("unmapped", 32'h0000_0000, rd);
      cmd(1'b1, SET, 32'h0001_0000);
      chk1("srst_out", 1'b1, srst);
      cmd(1'b0, SET, 32'h0000_0000);
      chk32("srst_busy", 32'h0081_0000, rd);
      repeat (20) @(negedge clk);
      cmd(1'b0, CLR, 32'h0000_0000);
      chk32("srst_done", 32'h0080_0000, rd);
      pulse(1'b1, 16'h0000, 16'h0000);
      cmd(1'b0, SET, 32'h0000_0000);
      chk32("allow_zero", 32'h0000_0000, rd);
      final_report();
   end
endmodule
